// ==== src/ssm_pkg.sv ====
// package: register indices, field positions and reset values for the supply status bank
package ssm_pkg;
   // register indices on the internal register port (no printed offsets)
   localparam logic [1:0] REG_FLAG_STATUS = 2'h0;
   localparam logic [1:0] REG_MON_ASSIGN = 2'h1;
   localparam logic [1:0] REG_SCALING = 2'h2;
   // data word is bits 23..8 of the serial frame, carried here as 16 bits [15:0]
   localparam int DATA_W = 16;
   // flag/status word field positions (frame bit minus 8)
   localparam int POS_LIN_REG_ON = 9;
   localparam int POS_PREREG_UVL = 7;
   localparam int POS_PREREG_UVH = 6;
   localparam int POS_SUPPLY_UVL = 5;
   localparam int POS_SUPPLY_UVH = 4;
   localparam int POS_WAKE_TWO_LIVE = 3;
   localparam int POS_WAKE_ONE_LIVE = 2;
   localparam int POS_WAKE_TWO_FLAG = 1;
   localparam int POS_WAKE_ONE_FLAG = 0;
   localparam int NUM_FLAGS = 6;
   // monitor assignment field [2:0]
   localparam int MON_ASSIGN_W = 3;
   localparam logic [2:0] MON_EXTERNAL = 3'h0;
   localparam logic [2:0] MON_PRE_REGULATOR = 3'h1;
   localparam logic [2:0] MON_LINEAR_REG_ONE = 3'h2;
   localparam logic [2:0] MON_RSVD_A = 3'h3;
   localparam logic [2:0] MON_RSVD_B = 3'h4;
   localparam logic [2:0] MON_BUCK_THREE = 3'h5;
   localparam logic [2:0] MON_ASSIGN_RST = 3'h0;
   // scaling offset field [4:0], 6.25 mV per step, 10000 is -100 mV
   localparam int SCALE_W = 5;
   localparam logic [4:0] SCALE_RST = 5'h00;
   localparam logic [4:0] SCALE_MAX = 5'h10;
   // flags except wake two come up set after power-on (wake by wake one, per reset table)
   localparam logic [5:0] FLAG_RST = 6'h3d;
   typedef enum logic [2:0] {
      SSM_MON_EXT = 3'h0,
      SSM_MON_PRE = 3'h1,
      SSM_MON_LIN = 3'h2,
      SSM_MON_BUCK_CONVERTER_THREE = 3'h3
   } ssm_mon_sel_t;
endpackage : ssm_pkg

// ==== src/ssm_sync2.sv ====
// two-flop synchroniser for a vector of asynchronous pin levels
`timescale 1ns/1ps
module ssm_sync2 #(
   parameter int WIDTH = 4
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } ssm_sync_state_t;

   ssm_sync_state_t st_r;
   ssm_sync_state_t st_nxt;

   always_comb begin
      st_nxt = st_r;
      st_nxt.meta = async_in;
      st_nxt.stable = st_r.meta;
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign sync_out = st_r.stable;
endmodule : ssm_sync2

// ==== src/ssm_supply_status.sv ====
// supply status flags, monitor assignment and buck scaling register slice
`timescale 1ns/1ps
module ssm_supply_status #(
   parameter int DATA_W = ssm_pkg::DATA_W
) (
   input wire logic clock,
   input wire logic sys_rst,
   // internal register port from the serial control block
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   output logic [DATA_W-1:0] reg_rdata,
   output logic reg_rvalid,
   // analog / pin status, asynchronous to clock
   input wire logic linear_reg_on,
   input wire logic wake_input_one,
   input wire logic wake_input_two,
   // event strobes from on-chip logic on the same clock
   input wire logic prereg_uvl_evt,
   input wire logic prereg_uvh_evt,
   input wire logic supply_uvl_evt,
   input wire logic supply_uvh_evt,
   input wire logic wake_one_evt,
   input wire logic wake_two_evt,
   // scaling offset from configuration memory, same clock
   input wire logic [ssm_pkg::SCALE_W-1:0] scaling_cfg,
   // decoded monitor one selection
   output ssm_pkg::ssm_mon_sel_t monitor_one_select,
   output logic monitor_one_assignment_rsvd
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [ssm_pkg::NUM_FLAGS-1:0] flags;
      logic [ssm_pkg::MON_ASSIGN_W-1:0] mon_assign;
      logic [ssm_pkg::SCALE_W-1:0] scaling;
      logic [DATA_W-1:0] rdata;
      logic rvalid;
      ssm_pkg::ssm_mon_sel_t mon_sel;
      logic mon_rsvd;
   } ssm_state_t;

   ssm_state_t st_r;
   ssm_state_t st_nxt;

   // ---------------------------------------------------------------
   // pin synchronisation
   // ---------------------------------------------------------------
   logic [2:0] live_sync;

   ssm_sync2 #(
      .WIDTH(3)
   ) u_sync (
      .clock(clock),
      .sys_rst(sys_rst),
      .async_in({linear_reg_on, wake_input_two, wake_input_one}),
      .sync_out(live_sync)
   );

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   // flag order: [5]pre uvl [4]pre uvh [3]sup uvl [2]sup uvh [1]wake two [0]wake one
   logic [ssm_pkg::NUM_FLAGS-1:0] flag_evt;
   logic [ssm_pkg::NUM_FLAGS-1:0] flag_clr;
   logic wr_flags;
   logic [DATA_W-1:0] status_word;

   always_comb begin
      flag_evt = {prereg_uvl_evt, prereg_uvh_evt, supply_uvl_evt, supply_uvh_evt,
                  wake_two_evt, wake_one_evt};
      wr_flags = reg_wr && (reg_addr == ssm_pkg::REG_FLAG_STATUS);
      flag_clr = '0;
      if (wr_flags) begin
         // only ones clear; a zero leaves the flag alone
         flag_clr = {reg_wdata[ssm_pkg::POS_PREREG_UVL], reg_wdata[ssm_pkg::POS_PREREG_UVH],
                     reg_wdata[ssm_pkg::POS_SUPPLY_UVL], reg_wdata[ssm_pkg::POS_SUPPLY_UVH],
                     reg_wdata[ssm_pkg::POS_WAKE_TWO_FLAG],
                     reg_wdata[ssm_pkg::POS_WAKE_ONE_FLAG]};
      end

      status_word = '0;
      status_word[ssm_pkg::POS_LIN_REG_ON] = live_sync[2];
      status_word[ssm_pkg::POS_PREREG_UVL] = st_r.flags[5];
      status_word[ssm_pkg::POS_PREREG_UVH] = st_r.flags[4];
      status_word[ssm_pkg::POS_SUPPLY_UVL] = st_r.flags[3];
      status_word[ssm_pkg::POS_SUPPLY_UVH] = st_r.flags[2];
      status_word[ssm_pkg::POS_WAKE_TWO_LIVE] = live_sync[1];
      status_word[ssm_pkg::POS_WAKE_ONE_LIVE] = live_sync[0];
      status_word[ssm_pkg::POS_WAKE_TWO_FLAG] = st_r.flags[1];
      status_word[ssm_pkg::POS_WAKE_ONE_FLAG] = st_r.flags[0];

      st_nxt = st_r;
      // a set arriving with its clear wins so no event is lost
      st_nxt.flags = (st_r.flags & ~flag_clr) | flag_evt;

      if (reg_wr && (reg_addr == ssm_pkg::REG_MON_ASSIGN)) begin
         st_nxt.mon_assign = reg_wdata[ssm_pkg::MON_ASSIGN_W-1:0];
      end
      // scaling field has no write path, software cannot change it
      st_nxt.scaling = scaling_cfg;

      // monitor decode: reserved codes fall back to external
      case (st_r.mon_assign)
         ssm_pkg::MON_PRE_REGULATOR: st_nxt.mon_sel = ssm_pkg::SSM_MON_PRE;
         ssm_pkg::MON_LINEAR_REG_ONE: st_nxt.mon_sel = ssm_pkg::SSM_MON_LIN;
         ssm_pkg::MON_BUCK_THREE: st_nxt.mon_sel = ssm_pkg::SSM_MON_BUCK_CONVERTER_THREE;
         default: st_nxt.mon_sel = ssm_pkg::SSM_MON_EXT;
      endcase
      st_nxt.mon_rsvd = (st_r.mon_assign == ssm_pkg::MON_RSVD_A) ||
                        (st_r.mon_assign == ssm_pkg::MON_RSVD_B);

      st_nxt.rvalid = reg_rd;
      st_nxt.rdata = '0;
      if (reg_rd) begin
         case (reg_addr)
            ssm_pkg::REG_FLAG_STATUS: st_nxt.rdata = status_word;
            ssm_pkg::REG_MON_ASSIGN: st_nxt.rdata[ssm_pkg::MON_ASSIGN_W-1:0] = st_r.mon_assign;
            ssm_pkg::REG_SCALING: st_nxt.rdata[ssm_pkg::SCALE_W-1:0] = st_r.scaling;
            default: st_nxt.rdata = '0;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         st_r.flags <= ssm_pkg::FLAG_RST;
         st_r.mon_assign <= ssm_pkg::MON_ASSIGN_RST;
         st_r.scaling <= ssm_pkg::SCALE_RST;
         st_r.rdata <= '0;
         st_r.rvalid <= 1'b0;
         st_r.mon_sel <= ssm_pkg::SSM_MON_EXT;
         st_r.mon_rsvd <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign reg_rdata = st_r.rdata;
   assign reg_rvalid = st_r.rvalid;
   assign monitor_one_select = st_r.mon_sel;
   assign monitor_one_assignment_rsvd = st_r.mon_rsvd;
endmodule : ssm_supply_status

// ==== test/ssm_supply_status_chk.sv ====
// checker for the supply status bank ports
`timescale 1ns/1ps
module ssm_supply_status_chk #(parameter int DATA_W = 16) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic [DATA_W-1:0] reg_rdata,
   input wire logic reg_rvalid,
   input wire logic linear_reg_on,
   input wire logic wake_input_one,
   input wire logic prereg_uvh_evt,
   input wire logic wake_one_evt,
   input wire logic wake_two_evt,
   input wire logic [4:0] scaling_cfg,
   input wire logic monitor_one_assignment_rsvd
);
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   // ----
   // live bits lag the pins by two flops, so only settled reads are judged
   // ----
   logic [1:0] up_r;
   always_ff @(posedge clock) up_r <= sys_rst ? 2'h0 : up_r + {1'b0, up_r != 2'h3};
   wire rd0 = reg_rd && !reg_wr && reg_addr == 2'h0;
   wire rl = rd0 && up_r == 2'h3;
   wire w0 = reg_wr && reg_addr == 2'h0;
   wire w1 = reg_wr && reg_addr == 2'h1;
   property p_lin;
      $stable(linear_reg_on)[*2] ##0 rl |=> reg_rdata[9] == $past(linear_reg_on);
   endproperty
   a_lin: assert property (p_lin) else $error("regulator state bit wrong");
   property p_wk1;
      $stable(wake_input_one)[*2] ##0 rl |=> reg_rdata[2] == $past(wake_input_one);
   endproperty
   a_wk1: assert property (p_wk1) else $error("wake one level wrong");
   property p_svs;
      reg_rd && reg_addr == 2'h2 && up_r == 2'h3 |=>
         reg_rvalid && reg_rdata == DATA_W'($past(scaling_cfg, 2));
   endproperty
   a_svs: assert property (p_svs) else $error("scaling read wrong");
   property p_set; prereg_uvh_evt ##1 rd0 |=> reg_rdata[6]; endproperty
   a_set: assert property (p_set) else $error("event flag not set");
   property p_w2; wake_two_evt ##1 rd0 |=> reg_rdata[1]; endproperty
   a_w2: assert property (p_w2) else $error("wake two flag not set");
   property p_clr; w0 && reg_wdata[0] && !wake_one_evt ##1 rd0 |=> !reg_rdata[0]; endproperty
   a_clr: assert property (p_clr) else $error("flag not cleared");
   property p_keep; reg_rdata[6] && w0 && !reg_wdata[6] ##1 rd0 |=> reg_rdata[6]; endproperty
   a_keep: assert property (p_keep) else $error("flag lost on zero write");
   property p_rsvd;
      w1 ##1 !w1 [*2] |=>
         monitor_one_assignment_rsvd == ($past(reg_wdata[2:0], 3) inside {3'h3, 3'h4});
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved code flag wrong");
   c_clr: cover property (w0 ##1 rd0);
   c_rsvd: cover property (monitor_one_assignment_rsvd);
   c_live: cover property (rl && linear_reg_on);
endmodule : ssm_supply_status_chk
bind ssm_supply_status ssm_supply_status_chk #(.DATA_W(DATA_W)) chk_u (.clock, .sys_rst,
   .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid, .linear_reg_on,
   .wake_input_one, .prereg_uvh_evt, .wake_one_evt, .wake_two_evt, .scaling_cfg,
   .monitor_one_assignment_rsvd);

// ==== test/ssm_tb_top.sv ====
// testbench: register access sequences for the supply status bank
`timescale 1ns/1ps
module supply_status_and_monitor_config_tb_top;
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [1:0] reg_addr = 2'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic [15:0] reg_rdata;
   logic reg_rvalid;
   logic linear_reg_on = 1'b0;
   logic wake_input_one = 1'b0;
   logic wake_input_two = 1'b0;
   logic [7:0] ev = 8'h00;
   logic [4:0] scaling_cfg = 5'h00;
   ssm_pkg::ssm_mon_sel_t monitor_one_select;
   logic monitor_one_assignment_rsvd;
   int n_fail = 0;
   int n_tests = 0;
   localparam logic [2:0] dec_tbl[8] = '{3'h0, 3'h1, 3'h2, 3'h0, 3'h0, 3'h3, 3'h0, 3'h0};
   always #2.5 clock = ~clock;
   ssm_supply_status dut_u (.clock, .sys_rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
      .reg_rdata, .reg_rvalid, .linear_reg_on, .wake_input_one, .wake_input_two,
      .prereg_uvl_evt(ev[7]), .prereg_uvh_evt(ev[6]), .supply_uvl_evt(ev[5]),
      .supply_uvh_evt(ev[4]), .wake_one_evt(ev[0]), .wake_two_evt(ev[1]), .scaling_cfg,
      .monitor_one_select, .monitor_one_assignment_rsvd);
   task chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task tick(input int n);
      repeat (n) @(negedge clock);
   endtask : tick
   // ----
   // requests rise at a falling edge and drop one cycle later
   // ----
   task wr(input logic [1:0] a, input logic [15:0] d);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      tick(1);
      reg_wr = 1'b0;
   endtask : wr
   task rd(input logic [1:0] a, input logic [15:0] e);
      reg_rd = 1'b1;
      reg_addr = a;
      tick(1);
      reg_rd = 1'b0;
      chk({15'h0, reg_rvalid}, 16'h0001);
      chk(reg_rdata, e);
   endtask : rd
   task test_done;
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : test_done
   initial begin
      repeat (2000) @(posedge clock);
      n_fail++;
      test_done;
   end
   initial begin
      tick(20);
      sys_rst = 1'b0;
      // reset flags sit at word bits 7..4 and 0, live bits still low
      rd(2'h0, 16'h00f1);
      wr(2'h0, 16'h0000);
      rd(2'h0, 16'h00f1);
      wr(2'h3, 16'hffff);
      rd(2'h1, 16'h0000);
      wr(2'h2, 16'hffff);
      rd(2'h2, 16'h0000);
      wr(2'h0, 16'hffff);
      rd(2'h3, 16'h0000);
      tick(1);
      rd(2'h0, 16'h0000);
      for (int i = 0; i < 8; i++) if (i != 2 && i != 3) begin
         ev = 8'h01 << i;
         tick(1);
         ev = 8'h00;
         rd(2'h0, 16'h0001 << i);
         wr(2'h0, 16'h0001 << i);
         rd(2'h0, 16'h0000);
      end
      linear_reg_on = 1'b1;
      wake_input_one = 1'b1;
      tick(3);
      rd(2'h0, 16'h0204);
      linear_reg_on = 1'b0;
      wake_input_one = 1'b0;
      wake_input_two = 1'b1;
      tick(3);
      rd(2'h0, 16'h0008);
      for (int v = 0; v < 8; v++) begin
         wr(2'h1, 16'(v));
         rd(2'h1, 16'(v));
         tick(1);
         chk({13'h0, monitor_one_select}, {13'h0, dec_tbl[v]});
         chk({15'h0, monitor_one_assignment_rsvd}, {15'h0, v == 3 || v == 4});
      end
      for (int s = 0; s < 17; s++) begin
         scaling_cfg = 5'(s);
         tick(1);
         rd(2'h2, 16'(s));
      end
      test_done;
   end
endmodule : supply_status_and_monitor_config_tb_top
